// ==== verilog/cbt_pkg.sv ====
// Purpose: shared constants and types of the CAN bit timing unit
// Assumes: aclk is the fast clock source, four times the instruction clock
// Notes: register map, field layout, reset values and timing counts live here
package cbt_pkg;
	localparam int AXI_AW = 8;
	localparam logic [7:0] OFF_CFG1 = 8'h00;
	localparam logic [7:0] OFF_CFG2 = 8'h04;
	localparam logic [7:0] OFF_CTRL = 8'h08;
	localparam logic [7:0] OFF_STAT = 8'h0C;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int CFG1_PRESC_LSB = 0;
	localparam int CFG1_JUMP_LSB = 6;
	localparam int CFG2_PROP_LSB = 0;
	localparam int CFG2_PH1_LSB = 3;
	localparam int CFG2_TRIPLE_BIT = 6;
	localparam int CFG2_PH2_LSB = 8;
	localparam int CTRL_CKSEL_BIT = 0;
	localparam int STAT_RX_BIT = 0;
	localparam int STAT_SEG_LSB = 1;
	localparam int STAT_TIMING_OK_BIT = 3;
	localparam int STAT_RATE_OK_BIT = 4;
	localparam logic [31:0] CFG1_RST = 32'h0000_0000;
	localparam logic [31:0] CFG2_RST = 32'h0000_0212;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [4:0] BIT_TQ_MIN = 5'h08;
	localparam logic [4:0] BIT_TQ_MAX = 5'h19;
	localparam int CKSEL_DIV = 4;
	localparam int CLK_PERIOD_NS = 100;
	localparam int MIN_BIT_TIME_NS = 1000;
	localparam int MIN_BIT_CYCLES = (MIN_BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef struct packed {
		logic [5:0] presc;
		logic [1:0] jump;
		logic [2:0] prop;
		logic [2:0] ph1;
		logic [2:0] ph2;
		logic       triple;
		logic       cksel;
	} cbt_cfg_t;

	typedef enum logic [1:0] {
		SEG_SYNC,
		SEG_PROP,
		SEG_PH1,
		SEG_PH2
	} cbt_seg_t;
endpackage

// ==== verilog/cbt_quantum_gen.sv ====
// Purpose: time quantum and half quantum strobes
// Assumes: cfg changes only between frames
// Notes: strobes come from flip-flops, one aclk cycle wide
`timescale 1ns/1ns
module cbt_quantum_gen (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire cbt_pkg::cbt_cfg_t cfg,
	output logic                   half_tick,
	output logic                   tq_tick
);
	typedef struct packed {
		logic [1:0] mdiv;
		logic [5:0] cnt;
		logic       phase;
		logic       half;
		logic       tq;
	} cbt_qg_t;

	cbt_qg_t qg_ff;
	cbt_qg_t nxt_qg;
	logic    men;

	assign men = !cfg.cksel || (qg_ff.mdiv == 2'(cbt_pkg::CKSEL_DIV - 1));

	// Prescaler then divide by two
	always_comb begin
		nxt_qg = qg_ff;
		nxt_qg.half = 1'b0;
		nxt_qg.tq = 1'b0;
		nxt_qg.mdiv = qg_ff.mdiv + 2'h1;
		// half quantum every field plus one
		if (men) begin
			if (qg_ff.cnt >= cfg.presc) begin
				nxt_qg.cnt = 6'h00;
				nxt_qg.half = 1'b1;
				nxt_qg.phase = ~qg_ff.phase;
				nxt_qg.tq = qg_ff.phase;
			end else begin
				nxt_qg.cnt = qg_ff.cnt + 6'h01;
			end
		end
		if (!aresetn) begin
			nxt_qg = '0;
		end
	end

	always_ff @(posedge aclk) begin
		qg_ff <= nxt_qg;
	end

	assign half_tick = qg_ff.half;
	assign tq_tick = qg_ff.tq;

	property p_tq_gap;
		@(posedge aclk) disable iff (!aresetn)
		tq_tick |=> !tq_tick;
	endproperty
	a_tq_gap: assert property (p_tq_gap) else $error("quantum strobes adjacent");

	property p_tq_half;
		@(posedge aclk) disable iff (!aresetn)
		tq_tick |-> half_tick;
	endproperty
	a_tq_half: assert property (p_tq_half) else $error("quantum not on half strobe");

	property p_cksel_slow;
		@(posedge aclk) disable iff (!aresetn)
		(half_tick && cfg.cksel && $past(cfg.cksel) && $past(cfg.cksel, 2)
			&& $past(cfg.cksel, 3)) |-> !$past(half_tick) && !$past(half_tick, 2);
	endproperty
	a_cksel_slow: assert property (p_cksel_slow) else $error("select ignored");
endmodule // cbt_quantum_gen

// ==== verilog/cbt_bit_timing.sv ====
// Purpose: CAN nominal bit timing, sampling and synchronization
// Assumes: rx and bus_idle are synchronous to aclk, rx high is recessive
// Notes: registers reached over AXI4-Lite, one word each
`timescale 1ns/1ns
module cbt_bit_timing (
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	input  wire logic [cbt_pkg::AXI_AW-1:0] awaddr,
	input  wire logic [2:0]                 awprot,
	input  wire logic                       awvalid,
	output logic                            awready,
	input  wire logic [31:0]                wdata,
	input  wire logic [3:0]                 wstrb,
	input  wire logic                       wvalid,
	output logic                            wready,
	output logic [1:0]                      bresp,
	output logic                            bvalid,
	input  wire logic                       bready,
	input  wire logic [cbt_pkg::AXI_AW-1:0] araddr,
	input  wire logic [2:0]                 arprot,
	input  wire logic                       arvalid,
	output logic                            arready,
	output logic [31:0]                     rdata,
	output logic [1:0]                      rresp,
	output logic                            rvalid,
	input  wire logic                       rready,
	input  wire logic                       rx,
	input  wire logic                       bus_idle,
	output logic                            rx_bit,
	output logic                            sample_pulse,
	output logic                            bit_start,
	output logic                            hard_sync,
	output logic                            resync
);
	typedef struct packed {
		cbt_pkg::cbt_cfg_t cfg;
		logic              aw_full;
		logic [7:0]        aw_addr;
		logic              w_full;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
		cbt_pkg::cbt_seg_t seg;
		logic [3:0]        cnt;
		logic [4:0]        pos;
		logic [2:0]        ext;
		logic [2:0]        shr;
		logic              hard;
		logic              resynced;
		logic              cfg_dirty;
		logic              prev_rx;
		logic              h1;
		logic              h2;
		logic              rx_bit;
		logic              sample;
		logic              bstart;
		logic              hsync;
		logic              rsync;
	} cbt_st_t;

	cbt_st_t     st_ff;
	cbt_st_t     nxt_st;
	logic        half_tick;
	logic        tq_tick;
	logic [4:0]  bit_tq;
	logic        timing_ok;
	logic [9:0]  tq_cyc;
	logic [14:0] bit_cyc;
	logic        rate_ok;
	logic [31:0] stat_img;
	logic [3:0]  ph2_cur;
	logic [2:0]  jump_cur;

	function automatic logic [3:0] seg_len(input logic [2:0] f);
		return {1'b0, f} + 4'h1;
	endfunction

	function automatic logic [7:0] word_addr(input logic [7:0] a);
		return {a[7:2], 2'b00};
	endfunction

	function automatic logic maj(input logic a, input logic b, input logic c);
		return (a & b) | (a & c) | (b & c);
	endfunction

	// Byte lanes of a write over the old word
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
			input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = n[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Config fields as software sees them
	function automatic logic [31:0] cfg_img(input cbt_pkg::cbt_cfg_t c, input logic [7:0] a);
		logic [31:0] r;
		r = 32'h0000_0000;
		if (a == cbt_pkg::OFF_CFG1) begin
			r[cbt_pkg::CFG1_PRESC_LSB +: 6] = c.presc;
			r[cbt_pkg::CFG1_JUMP_LSB +: 2] = c.jump;
		end else if (a == cbt_pkg::OFF_CFG2) begin
			r[cbt_pkg::CFG2_PROP_LSB +: 3] = c.prop;
			r[cbt_pkg::CFG2_PH1_LSB +: 3] = c.ph1;
			r[cbt_pkg::CFG2_TRIPLE_BIT] = c.triple;
			r[cbt_pkg::CFG2_PH2_LSB +: 3] = c.ph2;
		end else if (a == cbt_pkg::OFF_CTRL) begin
			r[cbt_pkg::CTRL_CKSEL_BIT] = c.cksel;
		end
		return r;
	endfunction

	// Fields back out of a written word
	function automatic cbt_pkg::cbt_cfg_t cfg_load(input cbt_pkg::cbt_cfg_t c,
			input logic [7:0] a, input logic [31:0] v);
		cbt_pkg::cbt_cfg_t r;
		r = c;
		if (a == cbt_pkg::OFF_CFG1) begin
			r.presc = v[cbt_pkg::CFG1_PRESC_LSB +: 6];
			r.jump = v[cbt_pkg::CFG1_JUMP_LSB +: 2];
		end else if (a == cbt_pkg::OFF_CFG2) begin
			r.prop = v[cbt_pkg::CFG2_PROP_LSB +: 3];
			r.ph1 = v[cbt_pkg::CFG2_PH1_LSB +: 3];
			r.triple = v[cbt_pkg::CFG2_TRIPLE_BIT];
			r.ph2 = v[cbt_pkg::CFG2_PH2_LSB +: 3];
		end else if (a == cbt_pkg::OFF_CTRL) begin
			r.cksel = v[cbt_pkg::CTRL_CKSEL_BIT];
		end
		return r;
	endfunction

	cbt_quantum_gen i_cbt_quantum_gen (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.cfg       (st_ff.cfg),
		.half_tick (half_tick),
		.tq_tick   (tq_tick)
	);

	// segment sum range check, one quantum for sync
	assign bit_tq = 5'h01 + 5'(seg_len(st_ff.cfg.prop)) + 5'(seg_len(st_ff.cfg.ph1))
		+ 5'(seg_len(st_ff.cfg.ph2));
	assign timing_ok = (bit_tq >= cbt_pkg::BIT_TQ_MIN) && (bit_tq <= cbt_pkg::BIT_TQ_MAX);
	// rate flag only; software owns the limit
	assign tq_cyc = {3'b000, 7'({1'b0, st_ff.cfg.presc} + 7'h01)} << (st_ff.cfg.cksel ? 2'd3 : 2'd1);
	assign bit_cyc = 15'(tq_cyc) * 15'(bit_tq);
	assign rate_ok = bit_cyc >= 15'(cbt_pkg::MIN_BIT_CYCLES);
	assign ph2_cur = seg_len(st_ff.cfg.ph2) - {1'b0, st_ff.shr};
	assign jump_cur = {1'b0, st_ff.cfg.jump} + 3'h1;

	// Read-only status word
	always_comb begin
		stat_img = 32'h0000_0000;
		stat_img[cbt_pkg::STAT_RX_BIT] = st_ff.rx_bit;
		stat_img[cbt_pkg::STAT_SEG_LSB +: 2] = st_ff.seg;
		stat_img[cbt_pkg::STAT_TIMING_OK_BIT] = timing_ok;
		stat_img[cbt_pkg::STAT_RATE_OK_BIT] = rate_ok;
	end

	// Holding slots block new requests, so no handshake is ever lost
	assign awready = !st_ff.aw_full && !st_ff.bvalid;
	assign wready = !st_ff.w_full && !st_ff.bvalid;
	assign arready = !st_ff.rvalid;

	// Bus slave and bit timing state
	always_comb begin
		logic [7:0]  wa;
		logic [7:0]  ra;
		logic        edge_fall;
		logic        early;
		logic [2:0]  ext_n;
		logic [2:0]  shr_n;
		logic [4:0]  err_late;
		logic [3:0]  rem_q;
		logic [3:0]  len_prop;
		logic [3:0]  len_ph1;
		logic [3:0]  len_ph2;
		logic        cfg_wr;
		wa = word_addr(st_ff.aw_addr);
		ra = word_addr(araddr);
		edge_fall = 1'b0;
		early = 1'b0;
		ext_n = st_ff.ext;
		shr_n = st_ff.shr;
		err_late = st_ff.pos + 5'h01;
		rem_q = ph2_cur - st_ff.cnt;
		len_prop = 4'h0;
		len_ph1 = 4'h0;
		len_ph2 = 4'h0;
		cfg_wr = 1'b0;
		nxt_st = st_ff;
		nxt_st.sample = 1'b0;
		nxt_st.bstart = 1'b0;
		nxt_st.hsync = 1'b0;
		nxt_st.rsync = 1'b0;

		// Write path, address and data in either order
		if (awvalid && awready) begin
			nxt_st.aw_full = 1'b1;
			nxt_st.aw_addr = awaddr;
		end
		if (wvalid && wready) begin
			nxt_st.w_full = 1'b1;
			nxt_st.wdata = wdata;
			nxt_st.wstrb = wstrb;
		end
		if (st_ff.aw_full && st_ff.w_full) begin
			nxt_st.aw_full = 1'b0;
			nxt_st.w_full = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = cbt_pkg::RESP_OKAY;
			if (wa == cbt_pkg::OFF_CFG1 || wa == cbt_pkg::OFF_CFG2 || wa == cbt_pkg::OFF_CTRL) begin
				nxt_st.cfg = cfg_load(st_ff.cfg, wa,
					merge(cfg_img(st_ff.cfg, wa), st_ff.wdata, st_ff.wstrb));
				// Bit in flight mixes old and new lengths
				cfg_wr = 1'b1;
				nxt_st.cfg_dirty = 1'b1;
			end else if (wa != cbt_pkg::OFF_STAT) begin
				nxt_st.bresp = cbt_pkg::RESP_SLVERR;
			end
		end
		if (st_ff.bvalid && bready) begin
			nxt_st.bvalid = 1'b0;
		end

		// Read path, one outstanding
		if (st_ff.rvalid && rready) begin
			nxt_st.rvalid = 1'b0;
		end
		if (arvalid && arready) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp = cbt_pkg::RESP_OKAY;
			if (ra == cbt_pkg::OFF_STAT) begin
				nxt_st.rdata = stat_img;
			end else if (ra == cbt_pkg::OFF_CFG1 || ra == cbt_pkg::OFF_CFG2
					|| ra == cbt_pkg::OFF_CTRL) begin
				nxt_st.rdata = cfg_img(st_ff.cfg, ra);
			end else begin
				nxt_st.rdata = 32'h0000_0000;
				nxt_st.rresp = cbt_pkg::RESP_SLVERR;
			end
		end

		// bus history at half quantum spacing
		if (half_tick) begin
			nxt_st.h1 = rx;
			nxt_st.h2 = st_ff.h1;
		end

		if (tq_tick) begin
			nxt_st.prev_rx = rx;
			// edge seen in the quantum just ended
			edge_fall = st_ff.prev_rx & ~rx;
			// one bounded adjustment per bit, none after hard sync
			if (edge_fall && !bus_idle && !st_ff.hard && !st_ff.resynced) begin
				unique case (st_ff.seg)
					cbt_pkg::SEG_PROP, cbt_pkg::SEG_PH1: begin
						ext_n = (err_late > {2'b00, jump_cur}) ? jump_cur : err_late[2:0];
						nxt_st.resynced = 1'b1;
						nxt_st.rsync = 1'b1;
					end
					cbt_pkg::SEG_PH2: begin
						if (rem_q <= {1'b0, jump_cur}) begin
							early = 1'b1;
						end else begin
							shr_n = jump_cur;
						end
						nxt_st.resynced = 1'b1;
						nxt_st.rsync = 1'b1;
					end
					cbt_pkg::SEG_SYNC: begin
						ext_n = st_ff.ext;
					end
				endcase
			end
			len_prop = seg_len(st_ff.cfg.prop);
			len_ph1 = seg_len(st_ff.cfg.ph1) + {1'b0, ext_n};
			len_ph2 = seg_len(st_ff.cfg.ph2) - {1'b0, shr_n};
			nxt_st.ext = ext_n;
			nxt_st.shr = shr_n;
			unique case (st_ff.seg)
				cbt_pkg::SEG_SYNC: begin
					nxt_st.seg = cbt_pkg::SEG_PROP;
					nxt_st.cnt = 4'h0;
					nxt_st.pos = 5'h00;
					nxt_st.ext = 3'h0;
					nxt_st.shr = 3'h0;
					nxt_st.hard = 1'b0;
					// Set wins: a write landing now taints the new bit
					nxt_st.cfg_dirty = cfg_wr;
					nxt_st.resynced = 1'b0;
				end
				cbt_pkg::SEG_PROP: begin
					nxt_st.pos = st_ff.pos + 5'h01;
					nxt_st.cnt = st_ff.cnt + 4'h1;
					if (st_ff.cnt + 4'h1 >= len_prop) begin
						nxt_st.seg = cbt_pkg::SEG_PH1;
						nxt_st.cnt = 4'h0;
					end
				end
				cbt_pkg::SEG_PH1: begin
					nxt_st.pos = st_ff.pos + 5'h01;
					nxt_st.cnt = st_ff.cnt + 4'h1;
					// sample point at end of phase one
					if (st_ff.cnt + 4'h1 >= len_ph1) begin
						nxt_st.seg = cbt_pkg::SEG_PH2;
						nxt_st.cnt = 4'h0;
						nxt_st.sample = 1'b1;
						nxt_st.rx_bit = st_ff.cfg.triple ? maj(rx, st_ff.h1, st_ff.h2) : rx;
					end
				end
				cbt_pkg::SEG_PH2: begin
					nxt_st.cnt = st_ff.cnt + 4'h1;
					if (st_ff.cnt + 4'h1 >= len_ph2) begin
						nxt_st.seg = cbt_pkg::SEG_SYNC;
						nxt_st.cnt = 4'h0;
						nxt_st.bstart = 1'b1;
					end
				end
			endcase
			// Early edge close to sync: that quantum becomes the new sync
			if (early) begin
				nxt_st.seg = cbt_pkg::SEG_PROP;
				nxt_st.cnt = 4'h0;
				nxt_st.pos = 5'h00;
				nxt_st.ext = 3'h0;
				nxt_st.shr = 3'h0;
				nxt_st.resynced = 1'b0;
				nxt_st.bstart = 1'b1;
			end
			// hard sync restarts the bit after the edge quantum
			if (edge_fall && bus_idle) begin
				nxt_st.seg = cbt_pkg::SEG_PROP;
				nxt_st.cnt = 4'h0;
				nxt_st.pos = 5'h00;
				nxt_st.ext = 3'h0;
				nxt_st.shr = 3'h0;
				nxt_st.hard = 1'b1;
				nxt_st.resynced = 1'b0;
				nxt_st.rsync = 1'b0;
				nxt_st.sample = 1'b0;
				nxt_st.hsync = 1'b1;
				nxt_st.bstart = 1'b1;
			end
			// illegal sum parks the sequencer; a half-valid bit is worse
			if (!timing_ok) begin
				nxt_st.seg = cbt_pkg::SEG_SYNC;
				nxt_st.cnt = 4'h0;
				// No pulses or new bit value from a parked sequencer
				nxt_st.rx_bit = st_ff.rx_bit;
				nxt_st.sample = 1'b0;
				nxt_st.bstart = 1'b0;
				nxt_st.hsync = 1'b0;
				nxt_st.rsync = 1'b0;
			end
		end

		if (!aresetn) begin
			nxt_st = '0;
			nxt_st.prev_rx = 1'b1;
			nxt_st.cfg = cfg_load(cfg_load(cfg_load(nxt_st.cfg, cbt_pkg::OFF_CFG1,
				cbt_pkg::CFG1_RST), cbt_pkg::OFF_CFG2, cbt_pkg::CFG2_RST),
				cbt_pkg::OFF_CTRL, cbt_pkg::CTRL_RST);
		end
	end

	always_ff @(posedge aclk) begin
		st_ff <= nxt_st;
	end

	assign bresp = st_ff.bresp;
	assign bvalid = st_ff.bvalid;
	assign rdata = st_ff.rdata;
	assign rresp = st_ff.rresp;
	assign rvalid = st_ff.rvalid;
	assign rx_bit = st_ff.rx_bit;
	assign sample_pulse = st_ff.sample;
	assign bit_start = st_ff.bstart;
	assign hard_sync = st_ff.hsync;
	assign resync = st_ff.rsync;

	property p_sync_one;
		@(posedge aclk) disable iff (!aresetn)
		(st_ff.seg == cbt_pkg::SEG_SYNC && tq_tick && timing_ok) |=> st_ff.seg != cbt_pkg::SEG_SYNC;
	endproperty
	a_sync_one: assert property (p_sync_one) else $error("sync longer than one quantum");

	property p_sample_ph1;
		@(posedge aclk) disable iff (!aresetn)
		sample_pulse |-> st_ff.seg == cbt_pkg::SEG_PH2 && $past(st_ff.seg) == cbt_pkg::SEG_PH1;
	endproperty
	a_sample_ph1: assert property (p_sample_ph1) else $error("sample not at phase one end");

	property p_single;
		@(posedge aclk) disable iff (!aresetn)
		(sample_pulse && !$past(st_ff.cfg.triple)) |-> rx_bit == $past(rx);
	endproperty
	a_single: assert property (p_single) else $error("single sample wrong");

	property p_majority;
		@(posedge aclk) disable iff (!aresetn)
		(sample_pulse && $past(st_ff.cfg.triple))
			|-> rx_bit == maj($past(rx), $past(st_ff.h1), $past(st_ff.h2));
	endproperty
	a_majority: assert property (p_majority) else $error("majority wrong");

	property p_prop_len;
		@(posedge aclk) disable iff (!aresetn)
		(st_ff.seg == cbt_pkg::SEG_PH1 && $past(st_ff.seg) == cbt_pkg::SEG_PROP
			&& !$past(st_ff.cfg_dirty))
			|-> $past(st_ff.cnt) == {1'b0, $past(st_ff.cfg.prop)};
	endproperty
	a_prop_len: assert property (p_prop_len) else $error("propagation length wrong");

	property p_ph2_len;
		@(posedge aclk) disable iff (!aresetn)
		(st_ff.seg == cbt_pkg::SEG_SYNC && $past(st_ff.seg) == cbt_pkg::SEG_PH2 && !resync
			&& !$past(st_ff.cfg_dirty))
			|-> $past(st_ff.cnt) + 4'h1 == $past(ph2_cur);
	endproperty
	a_ph2_len: assert property (p_ph2_len) else $error("phase two length wrong");

	property p_hard;
		@(posedge aclk) disable iff (!aresetn)
		hard_sync |-> $past(bus_idle) && st_ff.seg == cbt_pkg::SEG_PROP && st_ff.cnt == 4'h0;
	endproperty
	a_hard: assert property (p_hard) else $error("hard sync misplaced");

	property p_no_resync;
		@(posedge aclk) disable iff (!aresetn)
		resync |-> !$past(st_ff.hard) && !$past(bus_idle);
	endproperty
	a_no_resync: assert property (p_no_resync) else $error("resync after hard sync");

	property p_jump;
		@(posedge aclk) disable iff (!aresetn)
		st_ff.ext <= jump_cur && st_ff.shr <= jump_cur;
	endproperty
	a_jump: assert property (p_jump) else $error("jump beyond width");
endmodule // cbt_bit_timing

// ==== bench/cbt_can_node.sv ====
// Purpose: far-side CAN node model driving the receive line
// Assumes: 16-bit frames sent msb first, frame held steady by the bench
// Notes: line rests recessive between frames, as the bus bias does
`timescale 1ns/1ns
module cbt_can_node (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        go,
	input  wire logic [15:0] frame,
	input  wire logic [7:0]  bit_cycles,
	output logic             rx,
	output logic             busy
);
	logic [7:0] cyc_ff;
	logic [3:0] idx_ff;

	// One bit every bit_cycles clocks, slightly off the receiver's rate on purpose
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy <= 1'b0;
			rx <= 1'b1;
			cyc_ff <= 8'h00;
			idx_ff <= 4'h0;
		end else if (go && !busy) begin
			busy <= 1'b1;
			rx <= frame[15];
			cyc_ff <= 8'h00;
			idx_ff <= 4'hF;
		end else if (busy) begin
			cyc_ff <= cyc_ff + 8'h01;
			if (cyc_ff == bit_cycles - 8'h01) begin
				cyc_ff <= 8'h00;
				idx_ff <= idx_ff - 4'h1;
				busy <= idx_ff != 4'h0;
				rx <= (idx_ff == 4'h0) ? 1'b1 : frame[idx_ff - 4'h1];
			end
		end
	end
endmodule // cbt_can_node

// ==== bench/can_bit_timing_unit_tb.sv ====
// Purpose: self-checking bench of the CAN bit timing unit
// Assumes: one AXI4-Lite access at a time, aclk at 10 MHz
// Notes: node model drives rx; a monitor checks samples taken on a steady line and the bit spacing
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
$display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module can_bit_timing_unit_tb;
	localparam logic [7:0] a_c1 = cbt_pkg::OFF_CFG1;
	localparam logic [7:0] a_c2 = cbt_pkg::OFF_CFG2;
	localparam logic [7:0] a_ct = cbt_pkg::OFF_CTRL;
	localparam logic [7:0] a_st = cbt_pkg::OFF_STAT;
	localparam logic [1:0] ok = cbt_pkg::RESP_OKAY;
	localparam logic [1:0] bad = cbt_pkg::RESP_SLVERR;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, rx, bus_idle, rx_bit, sample_pulse;
	logic        bit_start, hard_sync, resync, go, busy, in_hs;
	logic [7:0]  awaddr, araddr, bit_cycles;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic [15:0] frame;
	logic [5:0]  hist;
	logic [31:0] tc1 [6] = '{32'h00, 32'h00, 32'h00, 32'h02, 32'hC0, 32'h3F};
	logic [31:0] tc2 [6] = '{32'h212, 32'h111, 32'h73F, 32'h212, 32'h212, 32'h111};
	logic        tcs [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
	int          num_errors, n_checks, n_hs, n_rs, iv, jw, nom, chk_iv, n, tq, hs0, rs0;

	cbt_bit_timing i_cbt_bit_timing (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .rx(rx), .bus_idle(bus_idle), .rx_bit(rx_bit),
		.sample_pulse(sample_pulse), .bit_start(bit_start), .hard_sync(hard_sync),
		.resync(resync));
	cbt_can_node i_cbt_can_node (
		.aclk(aclk), .aresetn(aresetn), .go(go), .frame(frame),
		.bit_cycles(bit_cycles), .rx(rx), .busy(busy));

	// 10 MHz clock
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	// Sample value, bit spacing and the hard-sync bit watched at every edge
	always @(posedge aclk) begin
		hist = {hist[4:0], rx};
		if (sample_pulse && (hist == 6'h00 || hist == 6'h3F))
			`CHK(rx_bit, hist[0])
		if (in_hs)
			`CHK(resync, 1'b0)
		if (hard_sync)
			in_hs = 1'b1;
		else if (bit_start)
			in_hs = 1'b0;
		if (bit_start && !hard_sync && chk_iv)
			`CHK(iv >= nom - jw && iv <= nom + jw, 1'b1)
		iv = (bit_start || hard_sync) ? 1 : iv + 1;
		n_hs += hard_sync;
		n_rs += resync;
	end

	task automatic end_sim();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Write holds each channel until its own ready, bready until bvalid
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int k;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (k = 0; k < 100; k++) begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid)
				break;
		end
		bready <= 1'b0;
		`CHK(bresp, er)
		if (k == 100) begin
			num_errors++;
			end_sim();
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] er);
		int k;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (k = 0; k < 100; k++) begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid)
				break;
		end
		rready <= 1'b0;
		`CHK(rdata & m, e)
		`CHK(rresp, er)
		if (k == 100) begin
			num_errors++;
			end_sim();
		end
	endtask

	// Bounded wait: 0 bit start, 1 sample, 2 hard sync; n is cycles taken
	task automatic wait_sig(input int w, output int c);
		c = 0;
		do begin
			@(posedge aclk);
			c++;
		end while (!(w == 0 ? bit_start : w == 1 ? sample_pulse : hard_sync) && c < 3000);
		if (c == 3000) begin
			num_errors++;
			end_sim();
		end
	endtask

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, go, chk_iv} = '0;
		{awaddr, araddr, wdata, frame} = '0;
		bus_idle = 1'b1;
		bit_cycles = 8'h15;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rd(a_c1, 32'hFFFF_FFFF, cbt_pkg::CFG1_RST, ok);
		rd(a_c2, 32'hFFFF_FFFF, cbt_pkg::CFG2_RST, ok);
		rd(a_ct, 32'hFFFF_FFFF, cbt_pkg::CTRL_RST, ok);
		rd(8'h10, 32'hFFFF_FFFF, 32'h0, bad);
		wr(8'h14, 32'h1, bad);
		// Timing table: divider ends, bit length ends, clock select
		for (int i = 0; i < 6; i++) begin
			wr(a_c1, tc1[i], ok);
			wr(a_c2, tc2[i], ok);
			wr(a_ct, {31'h0, tcs[i]}, ok);
			rd(a_c2, 32'h7FF, tc2[i], ok);
			wr(a_st, 32'h0, ok);
			rd(a_st, 32'h8, 32'h8, ok);
			tq = 2 * (tc1[i][5:0] + 1) * (tcs[i] ? 4 : 1);
			wait_sig(0, n);
			wait_sig(0, n);
			`CHK(n, tq * (4 + tc2[i][2:0] + tc2[i][5:3] + tc2[i][10:8]))
			wait_sig(1, n);
			wait_sig(0, n);
			`CHK(n, tq * (tc2[i][10:8] + 1))
		end
		// Seven quanta is one short of legal: sequencer must stop sampling
		wr(a_c1, 32'h0, ok);
		wr(a_ct, 32'h0, ok);
		wr(a_c2, 32'h110, ok);
		rd(a_st, 32'h8, 32'h0, ok);
		n = 0;
		repeat (300) begin
			@(posedge aclk);
			n += sample_pulse;
		end
		`CHK(n, 0)
		// Two frames: single sample with jump 1, triple sample with jump 4
		for (int f = 0; f < 2; f++) begin
			wr(a_c1, f ? 32'hC0 : 32'h0, ok);
			wr(a_c2, f ? 32'h462 : 32'h212, ok);
			jw = f ? 8 : 2;
			nom = f ? 28 : 20;
			hs0 = n_hs;
			rs0 = n_rs;
			bit_cycles <= f ? 8'h1F : 8'h15;
			frame <= 16'h2A55;
			go <= 1'b1;
			@(posedge aclk);
			go <= 1'b0;
			wait_sig(2, n);
			bus_idle <= 1'b0;
			chk_iv = 1;
			for (n = 0; n < 1000 && busy; n++)
				@(posedge aclk);
			`CHK(busy, 1'b0)
			chk_iv = 0;
			bus_idle <= 1'b1;
			`CHK(n_hs, hs0 + 1)
			`CHK(n_rs > rs0, 1'b1)
		end
		end_sim();
	end
endmodule // can_bit_timing_unit_tb
